// *** pms_mode_status.sv ***
// controller mode switches, status indicators and resources
//
// Functional notes
// - the port select switch gives the special protocol to exactly one port.
// - both serial ports keep native, modbus and vendor protocols enabled.
// - the halt switch stops the program while host traffic stays up.
// - halt switch on at power-on sets the primary port to 9600 8N1.
// - all three indicators are lit while the program loads at power-on.
// - power-on or watchdog reset without clock module flags clock invalid.
// - the clock indicator goes off once the host writes the calendar.
// - pause lights for bad memory, pause instruction, host halt or switch.
// - host toggle releases a pause except for bad memory or the switch.
// - a run-time error lights its indicator, halts, and keeps the cause.
// - only five run-time error causes are detected, others are ignored.
// - 256 relays, 64 timers and 64 counters are provided.
// - eight clock sources from 0.01 s up to one minute run freely.
// - eight sequencers of 32 steps decode each step as a contact.
// - the multidrop driver is on while sending, off after the last stop bit.
`timescale 1ns/10ps
module pms_mode_status import pms_pkg::*; #(
  parameter int unsigned HALF_10MS_CYC = BASE_HALF_CYC
) (
  // clock and reset
  input  wire logic                              clock_in,
  input  wire logic                              reset_in,
  // switch and module pins
  input  wire logic                              protocol_port_select_switch_in,
  input  wire logic                              program_halt_switch_in,
  input  wire logic                              retention_select_switch_in,
  input  wire logic                              rtc_module_present_in,
  // core events
  input  wire logic                              watchdog_reset_in,
  input  wire logic                              nvm_load_busy_in,
  input  wire logic                              nvm_corrupt_in,
  input  wire logic                              program_loaded_in,
  input  wire logic                              pause_instr_in,
  input  wire pms_rt_err_t                       rt_err_in,
  input  wire logic [NUM_SEQ-1:0][SEQ_STEP_W-1:0] seq_count_in,
  // multidrop transmitter
  input  wire logic                              mdp_tx_start_in,
  input  wire logic                              mdp_last_stop_in,
  // register port
  input  wire pms_bus_req_t                      bus_in,
  output logic [31:0]                            rdata_out,
  // port configuration
  output pms_port_cfg_t                          primary_serial_port_cfg_out,
  output pms_port_cfg_t                          multidrop_serial_port_cfg_out,
  output logic                                   mdp_driver_en_out,
  output logic                                   mdp_receiver_en_out,
  // indicators and state
  output logic                                   led_clock_error_out,
  output logic                                   led_pause_out,
  output logic                                   led_run_error_out,
  output logic                                   program_run_out,
  output logic                                   values_retentive_out,
  output logic                                   calendar_preset_out,
  output logic                                   irq_out,
  // clock sources and sequencer contacts
  output logic [NUM_CLK_SRC-1:0]                 clock_source_out,
  output logic [NUM_SEQ-1:0][SEQ_STEPS-1:0]      sequencer_step_contact_out
);
  logic [3:0] pin_s;
  logic       sel_s;
  logic       halt_s;
  logic       retain_s;
  logic       rtc_s;

  pms_sync #(.W(4)) u_sync (
    .clock_in (clock_in),
    .reset_in (reset_in),
    .async_in ({rtc_module_present_in, retention_select_switch_in,
                program_halt_switch_in, protocol_port_select_switch_in}),
    .sync_out (pin_s)
  );
  assign {rtc_s, retain_s, halt_s, sel_s} = pin_s;

  pms_clock_sources #(.HALF_BASE_CYC(HALF_10MS_CYC)) u_clk (
    .clock_in   (clock_in),
    .reset_in   (reset_in),
    .source_out (clock_source_out)
  );

  // power-on sequencing; waits for the synchroniser to settle first
  pms_pwr_t   pwr_q;
  pms_pwr_t   pwr_d;
  logic [1:0] settle_q;
  logic [1:0] settle_d;
  logic       baud_q;
  logic       baud_d;
  logic       por_pulse;

  always_comb begin
    pwr_d     = pwr_q;
    settle_d  = settle_q;
    baud_d    = baud_q;
    por_pulse = 1'b0;
    unique case (pwr_q)
      PWR_SETTLE: begin
        if (settle_q == SETTLE_CYC) begin
          pwr_d     = PWR_LOAD;
          baud_d    = halt_s;
          por_pulse = 1'b1;
        end else begin
          settle_d  = settle_q + 2'h1;
        end
      end
      PWR_LOAD: begin
        if (!nvm_load_busy_in) begin
          pwr_d = PWR_ACTIVE;
        end
      end
      PWR_ACTIVE: begin
      end
    endcase
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      pwr_q    <= PWR_SETTLE;
      settle_q <= 2'h0;
      baud_q   <= 1'b0;
    end else begin
      pwr_q    <= pwr_d;
      settle_q <= settle_d;
      baud_q   <= baud_d;
    end
  end

  // status flags; every hardware set wins over a clear in the same cycle, except a run-time error arriving while one is already latched
  logic           cmd_wr;
  logic           cal_wr;
  logic           toggle;
  logic           rtc_event;
  logic           err_accept;
  logic           err_legal;
  logic           pause_any;
  logic           clk_inv_q, clk_inv_d;
  logic           corrupt_q, corrupt_d;
  logic           instr_q, instr_d;
  logic           host_q, host_d;
  logic           run_err_q, run_err_d;
  logic [2:0]     err_code_q, err_code_d;
  logic [7:0]     err_func_q, err_func_d;
  logic           pause_prev_q;
  logic [2:0]     led_d;
  logic           run_d;
  logic           drv_d;
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] irq_stat_q, irq_stat_d;
  logic [IRQ_W-1:0] irq_en_q, irq_en_d;
  logic           irq_d;
  logic [31:0]    rdata_d;
  pms_port_cfg_t  pri_d, mdp_d;
  logic [NUM_SEQ-1:0][SEQ_STEPS-1:0] seq_d;

  always_comb begin
    cmd_wr     = bus_in.wr && (bus_in.addr == OFF_CMD);
    cal_wr     = cmd_wr && bus_in.wdata[CMD_CAL_SET];
    toggle     = cmd_wr && bus_in.wdata[CMD_PAUSE_TOGGLE];
    rtc_event  = (por_pulse | watchdog_reset_in) & ~rtc_s;
    clk_inv_d  = rtc_event | (clk_inv_q & ~cal_wr);
    corrupt_d  = nvm_corrupt_in | (corrupt_q & ~program_loaded_in);
    instr_d    = pause_instr_in | instr_q;
    host_d     = host_q;
    // bad memory or the switch lock the pause against host release
    if (toggle && !corrupt_q && !halt_s) begin
      if (instr_q || host_q) begin
        instr_d = pause_instr_in;
        host_d  = 1'b0;
      end else begin
        host_d  = 1'b1;
      end
    end
    err_legal  = rt_err_in.code inside {ERR_DIV0, ERR_STEP0, ERR_STACK,
                                        ERR_OPCODE, ERR_INDEX};
    err_accept = rt_err_in.valid & err_legal & ~run_err_q;
    run_err_d  = err_accept | (run_err_q & ~program_loaded_in);
    err_code_d = err_accept ? rt_err_in.code : err_code_q;
    err_func_d = err_accept ? rt_err_in.func : err_func_q;
    pause_any  = corrupt_q | instr_q | host_q | halt_s;
    if (pwr_q != PWR_ACTIVE) begin
      led_d = LED_RESET;
    end else begin
      led_d = {clk_inv_q, pause_any, run_err_q};
    end
    run_d = (pwr_q == PWR_ACTIVE) & ~pause_any & ~run_err_q;
    drv_d = mdp_tx_start_in | (mdp_driver_en_out & ~mdp_last_stop_in);
    ev = '0;
    ev[IRQ_RT_ERR]  = err_accept;
    ev[IRQ_PAUSE]   = pause_any & ~pause_prev_q;
    ev[IRQ_CLK_INV] = rtc_event;
    irq_stat_d = ev;
    irq_stat_d = irq_stat_d | irq_stat_q;
    if (bus_in.wr && (bus_in.addr == OFF_IRQ_CLR)) begin
      irq_stat_d = ev | (irq_stat_q & ~bus_in.wdata[IRQ_W-1:0]);
    end
    irq_en_d = irq_en_q;
    if (bus_in.wr && (bus_in.addr == OFF_IRQ_EN)) begin
      irq_en_d = bus_in.wdata[IRQ_W-1:0];
    end
    irq_d = |(irq_stat_d & irq_en_d);
    // only one port may own the special protocol
    pri_d = '{special: ~sel_s, native: 1'b1, modbus: 1'b1, vendor: 1'b1,
              baud_9600: baud_q};
    mdp_d = '{special: sel_s, native: 1'b1, modbus: 1'b1, vendor: 1'b1,
              baud_9600: 1'b0};
    for (int i = 0; i < NUM_SEQ; i++) begin
      seq_d[i] = SEQ_STEPS'(1) << seq_count_in[i];
    end
    rdata_d = 32'h0;
    if (bus_in.rd) begin
      unique case (bus_in.addr)
        OFF_STATUS:   rdata_d = {24'h0, retain_s, baud_q, sel_s, halt_s,
                                 corrupt_q, run_err_q, pause_any, clk_inv_q};
        OFF_ERROR:    rdata_d = {16'h0, err_func_q, 5'h0, err_code_q};
        OFF_RES:      rdata_d = {8'(NUM_COUNTERS), 8'(NUM_TIMERS),
                                 16'(NUM_RELAYS)};
        OFF_CLKSEQ:   rdata_d = {8'h0, 8'(SEQ_STEPS), 8'(NUM_SEQ),
                                 8'(NUM_CLK_SRC)};
        OFF_IRQ_STAT: rdata_d = {29'h0, irq_stat_q};
        OFF_IRQ_EN:   rdata_d = {29'h0, irq_en_q};
        default:      rdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      clk_inv_q    <= 1'b0;
      corrupt_q    <= 1'b0;
      instr_q      <= 1'b0;
      host_q       <= 1'b0;
      run_err_q    <= 1'b0;
      err_code_q   <= ERR_NONE;
      err_func_q   <= 8'h0;
      pause_prev_q <= 1'b0;
      irq_stat_q   <= '0;
      irq_en_q     <= '0;
      irq_out      <= 1'b0;
      rdata_out    <= 32'h0;
      {led_clock_error_out, led_pause_out, led_run_error_out} <= LED_RESET;
      program_run_out      <= 1'b0;
      values_retentive_out <= 1'b0;
      calendar_preset_out  <= 1'b0;
      mdp_driver_en_out    <= 1'b0;
      mdp_receiver_en_out  <= 1'b1;
      primary_serial_port_cfg_out   <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
      multidrop_serial_port_cfg_out <= '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
      sequencer_step_contact_out    <= '0;
    end else begin
      clk_inv_q    <= clk_inv_d;
      corrupt_q    <= corrupt_d;
      instr_q      <= instr_d;
      host_q       <= host_d;
      run_err_q    <= run_err_d;
      err_code_q   <= err_code_d;
      err_func_q   <= err_func_d;
      pause_prev_q <= pause_any;
      irq_stat_q   <= irq_stat_d;
      irq_en_q     <= irq_en_d;
      irq_out      <= irq_d;
      rdata_out    <= rdata_d;
      {led_clock_error_out, led_pause_out, led_run_error_out} <= led_d;
      program_run_out      <= run_d;
      values_retentive_out <= retain_s;
      calendar_preset_out  <= rtc_event;
      mdp_driver_en_out    <= drv_d;
      mdp_receiver_en_out  <= ~drv_d;
      primary_serial_port_cfg_out   <= pri_d;
      multidrop_serial_port_cfg_out <= mdp_d;
      sequencer_step_contact_out    <= seq_d;
    end
  end

  // checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);

  sequence s_cal_write;
    cal_wr && !rtc_event;
  endsequence
  sequence s_err_in;
    rt_err_in.valid && err_legal && !run_err_q;
  endsequence

  a_port_exclusive: assert property (
    primary_serial_port_cfg_out.special
      != multidrop_serial_port_cfg_out.special)
    else $error("special protocol not on exactly one port");
  a_port_follow: assert property (
    sel_s |=> multidrop_serial_port_cfg_out.special)
    else $error("multidrop port did not take special protocol");
  a_native_on: assert property (
    primary_serial_port_cfg_out.native && multidrop_serial_port_cfg_out.modbus
      && multidrop_serial_port_cfg_out.vendor)
    else $error("common protocol disabled on a port");
  a_halt_stops: assert property (
    halt_s |=> !program_run_out && led_pause_out)
    else $error("program ran with halt switch on");
  a_baud_strap: assert property (
    (pwr_q == PWR_SETTLE && settle_q == SETTLE_CYC)
      |=> ##1 primary_serial_port_cfg_out.baud_9600 == $past(halt_s, 2))
    else $error("primary rate not taken from halt switch");
  a_load_leds: assert property (
    (pwr_q == PWR_LOAD) |=> led_clock_error_out && led_pause_out
      && led_run_error_out)
    else $error("indicators not all lit during load");
  a_rtc_preset: assert property (
    (watchdog_reset_in && !rtc_s) |=> clk_inv_q && calendar_preset_out)
    else $error("clock invalid not raised after watchdog");
  a_rtc_clear: assert property (
    s_cal_write |=> !clk_inv_q
      ##1 (!led_clock_error_out || $past(pwr_q) != PWR_ACTIVE))
    else $error("clock indicator stayed on after calendar write");
  a_pause_lock: assert property (
    (corrupt_q && toggle && pwr_q == PWR_ACTIVE) |=> led_pause_out)
    else $error("host released a memory pause");
  a_rt_err: assert property (
    s_err_in |=> run_err_q ##1 (led_run_error_out && !program_run_out))
    else $error("run-time error not latched");
  a_rt_ignore: assert property (
    (rt_err_in.valid && !err_legal && !run_err_q) |=> !run_err_q)
    else $error("unlisted error cause was latched");
  a_seq_decode: assert property (
    !$past(reset_in) |-> sequencer_step_contact_out[0]
      == (SEQ_STEPS'(1) << $past(seq_count_in[0])))
    else $error("sequencer contact not one-hot of its counter");
  a_drv_off: assert property (
    (mdp_last_stop_in && !mdp_tx_start_in)
      |=> !mdp_driver_en_out && mdp_receiver_en_out)
    else $error("driver not released after last stop bit");
endmodule // pms_mode_status

// *** pms_pkg.sv ***
// package: constants, types and register map of the mode and status block
package pms_pkg;
  // clock and clock sources
  localparam int unsigned CLK_HZ         = 25_000_000;
  localparam int unsigned BASE_PERIOD_US = 10_000;
  localparam int unsigned BASE_HALF_CYC  =
    CLK_HZ / 1_000_000 * BASE_PERIOD_US / 2;
  localparam int unsigned NUM_CLK_SRC    = 8;
  localparam int unsigned CLK_SRC_MULT [NUM_CLK_SRC] =
    '{1, 2, 5, 10, 20, 50, 100, 6000};
  // resource counts
  localparam int unsigned NUM_RELAYS   = 256;
  localparam int unsigned NUM_TIMERS   = 64;
  localparam int unsigned NUM_COUNTERS = 64;
  localparam int unsigned NUM_SEQ      = 8;
  localparam int unsigned SEQ_STEPS    = 32;
  localparam int unsigned SEQ_STEP_W   = 5;
  // power-on settle time for the synchronised switches
  localparam logic [1:0]  SETTLE_CYC   = 2'h3;
  // register offsets
  localparam logic [7:0]  OFF_STATUS   = 8'h00;
  localparam logic [7:0]  OFF_CMD      = 8'h04;
  localparam logic [7:0]  OFF_ERROR    = 8'h08;
  localparam logic [7:0]  OFF_RES      = 8'h0C;
  localparam logic [7:0]  OFF_CLKSEQ   = 8'h10;
  localparam logic [7:0]  OFF_IRQ_STAT = 8'h14;
  localparam logic [7:0]  OFF_IRQ_CLR  = 8'h18;
  localparam logic [7:0]  OFF_IRQ_EN   = 8'h1C;
  // command bits
  localparam int unsigned CMD_PAUSE_TOGGLE = 0;
  localparam int unsigned CMD_CAL_SET      = 1;
  // interrupt bits
  localparam int unsigned IRQ_RT_ERR  = 0;
  localparam int unsigned IRQ_PAUSE   = 1;
  localparam int unsigned IRQ_CLK_INV = 2;
  localparam int unsigned IRQ_W       = 3;
  // reset values
  localparam logic [2:0]  LED_RESET   = 3'h7;
  // run-time error causes
  typedef enum logic [2:0] {
    ERR_NONE   = 3'h0,
    ERR_DIV0   = 3'h1,
    ERR_STEP0  = 3'h2,
    ERR_STACK  = 3'h3,
    ERR_OPCODE = 3'h4,
    ERR_INDEX  = 3'h5
  } pms_err_t;
  // power-on phases
  typedef enum logic [2:0] {
    PWR_SETTLE = 3'h1,
    PWR_LOAD   = 3'h2,
    PWR_ACTIVE = 3'h4
  } pms_pwr_t;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } pms_bus_req_t;
  typedef struct packed {
    logic       valid;
    logic [2:0] code;
    logic [7:0] func;
  } pms_rt_err_t;
  typedef struct packed {
    logic special;
    logic native;
    logic modbus;
    logic vendor;
    logic baud_9600;
  } pms_port_cfg_t;
endpackage

// *** pms_sync.sv ***
// two-flop synchroniser for pin levels
`timescale 1ns/10ps
module pms_sync #(
  parameter int unsigned W = 4
) (
  // clock and reset
  input  wire logic         clock_in,
  input  wire logic         reset_in,
  // levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // pms_sync

// *** pms_clock_sources.sv ***
// free-running square-wave clock sources
`timescale 1ns/10ps
module pms_clock_sources import pms_pkg::*; #(
  parameter int unsigned HALF_BASE_CYC = BASE_HALF_CYC
) (
  // clock and reset
  input  wire logic                   clock_in,
  input  wire logic                   reset_in,
  // sources
  output logic      [NUM_CLK_SRC-1:0] source_out
);
  genvar i;
  generate
    for (i = 0; i < NUM_CLK_SRC; i++) begin : g_src
      localparam logic [31:0] LAST = 32'(HALF_BASE_CYC * CLK_SRC_MULT[i] - 1);
      logic [31:0] cnt_q;
      logic [31:0] cnt_d;
      logic        lvl_d;
      always_comb begin
        cnt_d = cnt_q + 32'h1;
        lvl_d = source_out[i];
        if (cnt_q >= LAST) begin
          cnt_d = 32'h0;
          lvl_d = ~source_out[i];
        end
      end
      always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
          cnt_q         <= 32'h0;
          source_out[i] <= 1'b0;
        end else begin
          cnt_q         <= cnt_d;
          source_out[i] <= lvl_d;
        end
      end
    end
  endgenerate
endmodule // pms_clock_sources

// *** pms_mdp_model.sv ***
// behavioural multidrop transmitter queue that frames each send request made while idle
`timescale 1ns/10ps
// only the multidrop line turns around; primary needs four-wire converters
module pms_mdp_model #(
  parameter int unsigned CHAR_CYC = 10
) (
  // clock and reset
  input  wire logic       clock_in,
  input  wire logic       reset_in,
  // frame request
  input  wire logic       send_in,
  input  wire logic [3:0] chars_in,
  // transmitter events
  output logic            tx_start_out,
  output logic            last_stop_out,
  output logic            busy_out
);
  int unsigned left_q;

  always @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      {tx_start_out, last_stop_out, busy_out} <= 3'h0;
      left_q <= 0;
    end else begin
      // queue is one frame deep, a send while busy is dropped
      tx_start_out  <= send_in && !busy_out;
      last_stop_out <= busy_out && left_q == 1;
      if (send_in && !busy_out) begin
        busy_out <= 1'b1;
        left_q   <= chars_in * CHAR_CYC;
      end else if (busy_out) begin
        left_q   <= left_q - 1;
        busy_out <= left_q != 1;
      end
    end
  end
endmodule // pms_mdp_model

// *** tb_top.sv ***
// self-checking testbench of the mode and status block
`timescale 1ns/10ps
module tb_top import pms_pkg::*; ();
  logic        clock_in, reset_in, sel_sw, halt_sw, retain_sw, rtc_fit;
  logic        wdog, nvm_busy, nvm_bad, prog_loaded, pause_instr;
  logic        send, tx_start, last_stop, mdp_busy;
  pms_rt_err_t rt_err;
  pms_bus_req_t bus;
  logic [NUM_SEQ-1:0][SEQ_STEP_W-1:0] seq_count;
  logic [31:0] rdata;
  pms_port_cfg_t pri_cfg, mdp_cfg;
  logic        drv_en, rcv_en, led_clk, led_pause, led_err;
  logic        run, retentive, cal_preset, irq;
  logic [NUM_CLK_SRC-1:0] src;
  logic [NUM_SEQ-1:0][SEQ_STEPS-1:0] contact;
  int          miscompares, compares, presets;

  pms_mode_status #(.HALF_10MS_CYC(2)) pms_mode_status_inst (
    .clock_in(clock_in), .reset_in(reset_in),
    .protocol_port_select_switch_in(sel_sw),
    .program_halt_switch_in(halt_sw),
    .retention_select_switch_in(retain_sw),
    .rtc_module_present_in(rtc_fit), .watchdog_reset_in(wdog),
    .nvm_load_busy_in(nvm_busy), .nvm_corrupt_in(nvm_bad),
    .program_loaded_in(prog_loaded), .pause_instr_in(pause_instr),
    .rt_err_in(rt_err), .seq_count_in(seq_count),
    .mdp_tx_start_in(tx_start), .mdp_last_stop_in(last_stop),
    .bus_in(bus), .rdata_out(rdata),
    .primary_serial_port_cfg_out(pri_cfg),
    .multidrop_serial_port_cfg_out(mdp_cfg),
    .mdp_driver_en_out(drv_en), .mdp_receiver_en_out(rcv_en),
    .led_clock_error_out(led_clk), .led_pause_out(led_pause),
    .led_run_error_out(led_err), .program_run_out(run),
    .values_retentive_out(retentive), .calendar_preset_out(cal_preset),
    .irq_out(irq), .clock_source_out(src),
    .sequencer_step_contact_out(contact));

  pms_mdp_model #(.CHAR_CYC(10)) pms_mdp_model_inst (
    .clock_in(clock_in), .reset_in(reset_in), .send_in(send),
    .chars_in(4'h3), .tx_start_out(tx_start),
    .last_stop_out(last_stop), .busy_out(mdp_busy));

  task automatic chk(input string w, input logic [31:0] e, got);
    compares++;
    if (got !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", w, e, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in) bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock_in) bus <= '0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rdchk(input string w, logic [7:0] a, logic [31:0] m, e);
    @(posedge clock_in) bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clock_in) bus <= '0;
    #1 chk(w, e, rdata & m);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic power_up(input logic halt);
    @(posedge clock_in);
    {reset_in, nvm_busy, halt_sw} <= {2'h3, halt};
    tick(2);
    chk("in reset", 6'h39, {led_clk, led_pause, led_err, run, drv_en, rcv_en});
    repeat (10) @(posedge clock_in);
    reset_in <= 1'b0;
    tick(10);
    chk("leds loading", 3'h7, {led_clk, led_pause, led_err});
    @(posedge clock_in) nvm_busy <= 1'b0;
    tick(4);
  endtask
  task automatic stop_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge clock_in) if (cal_preset === 1'b1) presets++;

  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end
  initial begin
    repeat (20000) @(posedge clock_in);
    miscompares++;
    stop_test();
  end

  initial begin
    logic e;
    logic p;
    int   n, rises;
    {reset_in, sel_sw, halt_sw, retain_sw, rtc_fit, wdog} <= 6'h20;
    {nvm_busy, nvm_bad, prog_loaded, pause_instr, send} <= 5'h10;
    {rt_err, bus, seq_count} <= '0;
    power_up(1'b0);
    chk("leds loaded", 3'h4, {led_clk, led_pause, led_err});
    chk("presets", 32'h1, presets);
    chk("primary cfg", 5'h1E, pri_cfg);
    chk("multidrop cfg", 5'h0E, mdp_cfg);
    rdchk("resources", OFF_RES, '1, 32'h40400100);
    rdchk("clk seq", OFF_CLKSEQ, '1, 32'h00200808);
    rdchk("unmapped", 8'h24, '1, 32'h0);
    rdchk("write only", OFF_CMD, '1, 32'h0);
    wr(OFF_RES, 32'hFFFFFFFF);
    rdchk("read only", OFF_RES, '1, 32'h40400100);
    wr(OFF_IRQ_EN, 32'h0);
    tick(3);
    chk("irq masked", 1'b0, irq);
    rdchk("irq status", OFF_IRQ_STAT, 32'h7, 32'h4);
    wr(OFF_IRQ_EN, 32'h4);
    tick(3);
    chk("irq raised", 1'b1, irq);
    rdchk("irq enable", OFF_IRQ_EN, 32'h7, 32'h4);
    wr(OFF_IRQ_CLR, 32'h4);
    tick(3);
    chk("irq cleared", 1'b0, irq);
    wr(OFF_IRQ_EN, 32'h7);
    wr(OFF_CMD, 32'h2);
    tick(3);
    chk("clock led set", 1'b0, led_clk);
    @(posedge clock_in) wdog <= 1'b1;
    @(posedge clock_in) wdog <= 1'b0;
    tick(4);
    chk("clock led wdog", 1'b1, led_clk);
    chk("presets wdog", 32'h2, presets);
    wr(OFF_CMD, 32'h2);
    rtc_fit <= 1'b1;
    tick(6);
    @(posedge clock_in) wdog <= 1'b1;
    @(posedge clock_in) wdog <= 1'b0;
    tick(4);
    chk("module fitted", 2'h0, {led_clk, presets == 2 ? 1'b0 : 1'b1});
    wr(OFF_IRQ_CLR, 32'h7);
    @(posedge clock_in) {sel_sw, retain_sw} <= 2'h3;
    tick(6);
    chk("primary sel", 5'h0E, pri_cfg);
    chk("multidrop sel", 5'h1E, mdp_cfg);
    chk("retentive", 1'b1, retentive);
    rdchk("status", OFF_STATUS, 32'hFF, 32'hA0);
    // causes: host halt, pause instruction, bad memory, halt switch
    for (int k = 0; k < 4; k++) begin
      @(posedge clock_in);
      case (k)
        0: wr(OFF_CMD, 32'h1);
        1: pause_instr <= 1'b1;
        2: nvm_bad <= 1'b1;
        default: halt_sw <= 1'b1;
      endcase
      @(posedge clock_in) {pause_instr, nvm_bad} <= 2'h0;
      tick(6);
      chk("paused", 2'h2, {led_pause, run});
      if (k == 3) rdchk("host active", OFF_RES, '1, 32'h40400100);
      wr(OFF_CMD, 32'h1);
      tick(4);
      chk("toggle", k < 2 ? 2'h1 : 2'h2, {led_pause, run});
      @(posedge clock_in);
      if (k == 2) prog_loaded <= 1'b1;
      if (k == 3) halt_sw <= 1'b0;
      @(posedge clock_in) prog_loaded <= 1'b0;
      tick(6);
      chk("released", 2'h1, {led_pause, run});
    end
    rdchk("pause irq", OFF_IRQ_STAT, 32'h2, 32'h2);
    wr(OFF_IRQ_CLR, 32'h7);
    for (int c = 0; c < 8; c++) begin
      e = c >= 1 && c <= 5;
      @(posedge clock_in) rt_err <= '{1'b1, c[2:0], 8'h30 + 8'(c)};
      // a second error while one is latched must not overwrite it
      if (e) @(posedge clock_in) rt_err <= '{1'b1, 3'h5, 8'hAA};
      @(posedge clock_in) rt_err <= '0;
      tick(4);
      chk("run error", {e, !e, e}, {led_err, run, irq});
      if (e) rdchk("cause", OFF_ERROR, '1, {16'h0, 8'h30 + 8'(c), 5'h0, c[2:0]});
      @(posedge clock_in) prog_loaded <= 1'b1;
      @(posedge clock_in) prog_loaded <= 1'b0;
      wr(OFF_IRQ_CLR, 32'h7);
      tick(4);
      chk("error cleared", 3'h2, {led_err, run, irq});
    end
    for (int k = 0; k < 2; k++) begin
      @(posedge clock_in);
      for (int s = 0; s < NUM_SEQ; s++) seq_count[s] <= k ? 31 - 4 * s : 4 * s;
      tick(3);
      for (int s = 0; s < NUM_SEQ; s++)
        chk("step contact", 32'h1 << (k ? 31 - 4 * s : 4 * s), contact[s]);
    end
    @(posedge clock_in) send <= 1'b1;
    @(posedge clock_in) send <= 1'b0;
    tick(3);
    chk("driver on", 2'h2, {drv_en, rcv_en});
    tick(20);
    chk("driver held", 2'h2, {drv_en, rcv_en});
    n = 0;
    while (mdp_busy && n < 100) begin tick(1); n++; end
    tick(3);
    chk("driver off", 2'h1, {drv_en, rcv_en});
    for (int i = 0; i < 7; i++) begin
      rises = 0;
      n = 0;
      p = src[i];
      while (rises < 2 && n < 2000) begin
        tick(1);
        if (rises == 1) n++;
        if (src[i] && !p) rises++;
        p = src[i];
      end
      chk("source period", 4 * CLK_SRC_MULT[i], n);
    end
    presets = 0;
    power_up(1'b1);
    chk("primary 9600", 5'h0F, pri_cfg);
    chk("multidrop kept", 5'h1E, mdp_cfg);
    chk("halted", 2'h2, {led_pause, run});
    @(posedge clock_in) halt_sw <= 1'b0;
    tick(6);
    chk("baud latched", 2'h3, {pri_cfg.baud_9600, run});
    stop_test();
  end
endmodule // tb_top
